/* File: verilog/rfm_pkg.sv */
// Package with register map, reset values, field positions and types
// ****************************************************************
// Overview of operation
// R1: Clearing bit 6 of the rail enable/disable register turns switch pair B off, overriding its force-on bit.
// R2: Clearing bit 5 of that register holds switch A off, with priority over its force-on input.
// R3: Clearing bit 4 keeps the termination LDO off, overriding its force-on; its reset value depends on the variant.
// R4: Setting bit 3 turns the termination LDO on regardless of sequencing unless its disable bit is 0.
// R5: Setting bit 1 enables switch pair B regardless of sequencing unless its disable bit is 0.
// R6: With bit 0 clear the third aux LDO follows the shared enable pin; with bit 0 set it is on anyway.
// R7: Bit 5 of the output control register at 0 drives the open-drain output low, at 1 releases it; reset 0x20.
// R8: Bits 7 and 6 of the first mask register mask aux LDO two and switch A faults; both reset masked.
// R9: Bits 5 to 0 of the first mask register mask step-down rails 6 to 1; all reset unmasked.
// R10: Bits 5, 4 and 0 of the second mask register mask analog 5 V, aux LDO one and aux LDO three; reset 0x37.
// R11: Bit 3 of the second mask register masks termination LDO faults and resets to 0.
// R12: Bits 2 to 1 mask switch pair B faults, 00 unmasked and 11 masked, reset 11; codes 01 and 10 are not written.
// R13: Every unmasked rail fault is combined into one shutdown request.
// R14: Each overridable rail is enabled when its disable bit is 1 and its force-on or sequencer enable is 1.
// ****************************************************************
package rfm_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_RAIL_CTRL3 = 8'h9F;
    localparam logic [7:0] OFS_OUT_CTRL = 8'hA1;
    localparam logic [7:0] OFS_MASK_FIRST = 8'hA2;
    localparam logic [7:0] OFS_MASK_SECOND = 8'hA3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_RAIL_CTRL3_A = 8'h68;
    localparam logic [7:0] RST_RAIL_CTRL3_B = 8'h70;
    localparam logic [7:0] RST_OUT_CTRL = 8'h20;
    localparam logic [7:0] RST_MASK_FIRST = 8'hC0;
    localparam logic [7:0] RST_MASK_SECOND = 8'h37;
    localparam logic [7:0] MASK_SECOND_RW = 8'h7F;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [6:0] DEF_BUS_ADDR = 7'h2A;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_SWB_OFF_N = 6;
    localparam int BIT_SWA_OFF_N = 5;
    localparam int BIT_TERM_OFF_N = 4;
    localparam int BIT_TERM_FORCE = 3;
    localparam int BIT_SWB_FORCE = 1;
    localparam int BIT_AUX3_FORCE = 0;
    localparam int BIT_OD_LEVEL = 5;
    localparam int BIT_AUX2_MASK = 7;
    localparam int BIT_SWA_MASK = 6;
    localparam int BIT_A5V_MASK = 5;
    localparam int BIT_AUX1_MASK = 4;
    localparam int BIT_TERM_MASK = 3;
    localparam int BIT_SWB_MASK_HI = 2;
    localparam int BIT_SWB_MASK_LO = 1;
    localparam int BIT_AUX3_MASK = 0;
    localparam int NUM_STEP_DOWN = 6;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [NUM_STEP_DOWN-1:0] step_down; // Bit 0 is rail 1
        logic switch_a;
        logic aux_ldo_two;
        logic analog_5v_supply;
        logic aux_ldo_one;
        logic termination_ldo;
        logic switch_pair_b;
        logic aux_ldo_three;
    } rfm_fault_t;

    typedef struct packed {
        logic switch_pair_b;
        logic switch_a;
        logic termination_ldo;
    } rfm_seq_t;

    typedef struct packed {
        logic switch_pair_b;
        logic switch_a;
        logic termination_ldo;
        logic aux_ldo_three;
    } rfm_rail_en_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_REG = 4'h3,
        ST_REG_ACK = 4'h4,
        ST_WR = 4'h5,
        ST_WR_ACK = 4'h6,
        ST_RD = 4'h7,
        ST_RD_ACK = 4'h8
    } rfm_state_t;

endpackage

/* File: verilog/rfm_regs.sv */
// Rail enable and fault mask register bank behind an I2C target port
`timescale 1ns/1ps
module rfm_regs #(
    parameter logic [6:0] BUS_ADDR = rfm_pkg::DEF_BUS_ADDR, // Arbitrary
    parameter logic VARIANT_B = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic shared_ldo_switch_enable_pin,
    input wire logic switch_a_force_on,
    input wire rfm_pkg::rfm_seq_t seq_en,
    input wire rfm_pkg::rfm_fault_t rail_fault,
    output rfm_pkg::rfm_rail_en_t rail_en,
    output logic shutdown_req,
    output logic open_drain_o,
    output logic open_drain_oe
);

    localparam logic [7:0] CTRL3_RST =
        VARIANT_B ? rfm_pkg::RST_RAIL_CTRL3_B : rfm_pkg::RST_RAIL_CTRL3_A;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic scl_s1_r, scl_s2_r, scl_s3_r;
    logic sda_s1_r, sda_s2_r, sda_s3_r;
    logic pin_s1_r, pin_s2_r;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    // Two stages before use, third only for edge detection
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_s3_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_s3_r <= 1'b1;
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
        end else begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            scl_s3_r <= scl_s2_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
            sda_s3_r <= sda_s2_r;
            pin_s1_r <= shared_ldo_switch_enable_pin;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Bus events
    assign scl_rise = scl_s2_r & ~scl_s3_r;
    assign scl_fall = ~scl_s2_r & scl_s3_r;
    assign bus_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
    assign bus_stop = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

    // ****************************************************************
    // Registers and read decode
    // ****************************************************************
    logic [7:0] ctrl3_r, ctrl3_nxt;
    logic [7:0] gpo_r, gpo_nxt;
    logic [7:0] mask1_r, mask1_nxt;
    logic [7:0] mask2_r, mask2_nxt;

    // Read value of one offset; unmapped offsets read zero
    function automatic logic [7:0] rd_mux(input logic [7:0] ofs,
                                          input logic [7:0] c3,
                                          input logic [7:0] g,
                                          input logic [7:0] m1,
                                          input logic [7:0] m2);
        logic [7:0] v;
        v = rfm_pkg::RST_ZERO;
        unique case (ofs)
            rfm_pkg::OFS_RAIL_CTRL3: v = c3;
            rfm_pkg::OFS_OUT_CTRL: v = g;
            rfm_pkg::OFS_MASK_FIRST: v = m1;
            rfm_pkg::OFS_MASK_SECOND: v = m2 & rfm_pkg::MASK_SECOND_RW;
            default: v = rfm_pkg::RST_ZERO;
        endcase
        return v;
    endfunction

    // ****************************************************************
    // I2C target state machine
    // ****************************************************************
    rfm_pkg::rfm_state_t state_r, state_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt;
    logic rw_r, rw_nxt;
    logic nack_r, nack_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic drive_low_r, drive_low_nxt;
    logic [7:0] rd_data;

    assign rd_data = rd_mux(ptr_r, ctrl3_r, gpo_r, mask1_r, mask2_r);

    // Next state, shift, pointer and register writes
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        rw_nxt = rw_r;
        nack_nxt = nack_r;
        shift_nxt = shift_r;
        ptr_nxt = ptr_r;
        drive_low_nxt = drive_low_r;
        ctrl3_nxt = ctrl3_r;
        gpo_nxt = gpo_r;
        mask1_nxt = mask1_r;
        mask2_nxt = mask2_r;
        if (bus_start) begin
            state_nxt = rfm_pkg::ST_ADDR;
            cnt_nxt = 3'h0;
            done_nxt = 1'b0;
            drive_low_nxt = 1'b0;
        end else if (bus_stop) begin
            state_nxt = rfm_pkg::ST_IDLE;
            drive_low_nxt = 1'b0;
        end else if (scl_rise) begin
            if (state_r == rfm_pkg::ST_RD_ACK) begin
                nack_nxt = sda_s2_r;
            end else if (state_r != rfm_pkg::ST_RD) begin
                shift_nxt = {shift_r[6:0], sda_s2_r};
            end
            cnt_nxt = cnt_r + 3'h1;
            done_nxt = (cnt_r == 3'h7);
        end else if (scl_fall) begin
            unique case (state_r)
                rfm_pkg::ST_IDLE: begin
                    drive_low_nxt = 1'b0;
                end
                rfm_pkg::ST_ADDR: begin
                    if (done_r) begin
                        done_nxt = 1'b0;
                        rw_nxt = shift_r[0];
                        if (shift_r[7:1] == BUS_ADDR) begin
                            state_nxt = rfm_pkg::ST_ADDR_ACK;
                            drive_low_nxt = 1'b1;
                        end else begin
                            state_nxt = rfm_pkg::ST_IDLE;
                        end
                    end
                end
                rfm_pkg::ST_ADDR_ACK, rfm_pkg::ST_REG_ACK,
                rfm_pkg::ST_WR_ACK, rfm_pkg::ST_RD_ACK: begin
                    cnt_nxt = 3'h0;
                    done_nxt = 1'b0;
                    drive_low_nxt = 1'b0;
                    if (state_r == rfm_pkg::ST_ADDR_ACK && !rw_r) begin
                        state_nxt = rfm_pkg::ST_REG;
                    end else if (state_r == rfm_pkg::ST_REG_ACK ||
                                 state_r == rfm_pkg::ST_WR_ACK) begin
                        state_nxt = rfm_pkg::ST_WR;
                    end else if (state_r == rfm_pkg::ST_RD_ACK && nack_r) begin
                        state_nxt = rfm_pkg::ST_IDLE;
                    end else begin
                        // Load next read byte and drive its top bit
                        state_nxt = rfm_pkg::ST_RD;
                        shift_nxt = rd_data;
                        ptr_nxt = ptr_r + 8'h01;
                        drive_low_nxt = ~rd_data[7];
                    end
                end
                rfm_pkg::ST_REG: begin
                    if (done_r) begin
                        state_nxt = rfm_pkg::ST_REG_ACK;
                        ptr_nxt = shift_r;
                        drive_low_nxt = 1'b1;
                    end
                end
                rfm_pkg::ST_WR: begin
                    if (done_r) begin
                        state_nxt = rfm_pkg::ST_WR_ACK;
                        drive_low_nxt = 1'b1;
                        ptr_nxt = ptr_r + 8'h01;
                        unique case (ptr_r)
                            rfm_pkg::OFS_RAIL_CTRL3: ctrl3_nxt = shift_r; // R1
                            rfm_pkg::OFS_OUT_CTRL: gpo_nxt = shift_r; // R7
                            rfm_pkg::OFS_MASK_FIRST: mask1_nxt = shift_r; // R8
                            rfm_pkg::OFS_MASK_SECOND: begin
                                mask2_nxt = shift_r & rfm_pkg::MASK_SECOND_RW;
                            end
                            default: ;
                        endcase
                    end
                end
                rfm_pkg::ST_RD: begin
                    if (done_r) begin
                        state_nxt = rfm_pkg::ST_RD_ACK;
                        drive_low_nxt = 1'b0;
                    end else begin
                        shift_nxt = {shift_r[6:0], 1'b0};
                        drive_low_nxt = ~shift_r[6];
                    end
                end
                default: state_nxt = rfm_pkg::ST_IDLE;
            endcase
        end
    end

    // Register the bus and register bank state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= rfm_pkg::ST_IDLE;
            cnt_r <= 3'h0;
            done_r <= 1'b0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            shift_r <= rfm_pkg::RST_ZERO;
            ptr_r <= rfm_pkg::RST_ZERO;
            drive_low_r <= 1'b0;
            ctrl3_r <= CTRL3_RST; // R3
            gpo_r <= rfm_pkg::RST_OUT_CTRL; // R7
            mask1_r <= rfm_pkg::RST_MASK_FIRST; // R8 R9
            mask2_r <= rfm_pkg::RST_MASK_SECOND; // R10 R11 R12
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
            rw_r <= rw_nxt;
            nack_r <= nack_nxt;
            shift_r <= shift_nxt;
            ptr_r <= ptr_nxt;
            drive_low_r <= drive_low_nxt;
            ctrl3_r <= ctrl3_nxt;
            gpo_r <= gpo_nxt;
            mask1_r <= mask1_nxt;
            mask2_r <= mask2_nxt;
        end
    end

    // Open-drain data line
    assign sda_o = 1'b0;
    assign sda_oe = drive_low_r;

    // ****************************************************************
    // Rail enables and shutdown request
    // ****************************************************************
    rfm_pkg::rfm_rail_en_t en_r, en_nxt;
    logic shut_r, shut_nxt;
    logic od_oe_r, od_oe_nxt;
    rfm_pkg::rfm_fault_t live;

    // Effective enables, unmasked faults and output level
    always_comb begin
        en_nxt.switch_pair_b = ctrl3_r[rfm_pkg::BIT_SWB_OFF_N] &
            (ctrl3_r[rfm_pkg::BIT_SWB_FORCE] | seq_en.switch_pair_b); // R1 R5 R14
        en_nxt.switch_a = ctrl3_r[rfm_pkg::BIT_SWA_OFF_N] &
            (switch_a_force_on | seq_en.switch_a); // R2 R14
        en_nxt.termination_ldo = ctrl3_r[rfm_pkg::BIT_TERM_OFF_N] &
            (ctrl3_r[rfm_pkg::BIT_TERM_FORCE] | seq_en.termination_ldo); // R3 R4 R14
        en_nxt.aux_ldo_three = ctrl3_r[rfm_pkg::BIT_AUX3_FORCE] | pin_s2_r; // R6
        live.step_down = rail_fault.step_down &
            ~mask1_r[rfm_pkg::NUM_STEP_DOWN-1:0]; // R9
        live.switch_a = rail_fault.switch_a &
            ~mask1_r[rfm_pkg::BIT_SWA_MASK]; // R8
        live.aux_ldo_two = rail_fault.aux_ldo_two &
            ~mask1_r[rfm_pkg::BIT_AUX2_MASK]; // R8
        live.analog_5v_supply = rail_fault.analog_5v_supply &
            ~mask2_r[rfm_pkg::BIT_A5V_MASK]; // R10
        live.aux_ldo_one = rail_fault.aux_ldo_one &
            ~mask2_r[rfm_pkg::BIT_AUX1_MASK]; // R10
        live.termination_ldo = rail_fault.termination_ldo &
            ~mask2_r[rfm_pkg::BIT_TERM_MASK]; // R11
        live.switch_pair_b = rail_fault.switch_pair_b &
            ~(mask2_r[rfm_pkg::BIT_SWB_MASK_HI] &
              mask2_r[rfm_pkg::BIT_SWB_MASK_LO]); // R12
        live.aux_ldo_three = rail_fault.aux_ldo_three &
            ~mask2_r[rfm_pkg::BIT_AUX3_MASK]; // R10
        shut_nxt = |live; // R13
        od_oe_nxt = ~gpo_r[rfm_pkg::BIT_OD_LEVEL]; // R7
    end

    // Register the rail side outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_r <= '0;
            shut_r <= 1'b0;
            od_oe_r <= 1'b0;
        end else begin
            en_r <= en_nxt;
            shut_r <= shut_nxt;
            od_oe_r <= od_oe_nxt;
        end
    end

    assign rail_en = en_r;
    assign shutdown_req = shut_r;
    assign open_drain_o = 1'b0;
    assign open_drain_oe = od_oe_r;

endmodule

/* File: bench/rfm_regs_properties.sv */
// Checker of the rail enable and fault mask bank at its ports
`timescale 1ns/1ps
module rfm_regs_checker #(
    parameter logic VARIANT_B = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic shared_ldo_switch_enable_pin,
    input wire logic switch_a_force_on,
    input wire rfm_pkg::rfm_seq_t seq_en,
    input wire rfm_pkg::rfm_fault_t rail_fault,
    input wire rfm_pkg::rfm_rail_en_t rail_en,
    input wire logic shutdown_req,
    input wire logic open_drain_o,
    input wire logic open_drain_oe
);
    // ****
    // Bus history: registers keep reset values until a START
    // ****
    logic sda_q_r, sda_q_nxt, used_r, used_nxt, idle;
    logic [2:0] age_r, age_nxt;
    // Next values of the history flags
    always_comb begin
        sda_q_nxt = sda_i;
        used_nxt = used_r | (scl_i & sda_q_r & !sda_i);
        age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
    end
    // History registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_q_r <= 1'b1;
            used_r <= 1'b0;
            age_r <= 3'h0;
        end else begin
            sda_q_r <= sda_q_nxt;
            used_r <= used_nxt;
            age_r <= age_nxt;
        end
    end
    // Synchroniser and output flops settled, no traffic yet
    assign idle = !used_r && (age_r >= 3'h4);
    default clocking dck @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // ****
    // Properties
    // ****
    switch_cause_a: assert property (
        rail_en.switch_a |-> $past(seq_en.switch_a | switch_a_force_on))
        else $error("switch A on without request");
    shutdown_cause_a: assert property (
        shutdown_req |-> $past(|rail_fault))
        else $error("shutdown without fault");
    idle_swa_a: assert property (
        idle |-> rail_en.switch_a ==
            $past(seq_en.switch_a | switch_a_force_on))
        else $error("switch A enable wrong at reset setting");
    idle_swb_a: assert property (
        idle |-> rail_en.switch_pair_b == $past(seq_en.switch_pair_b))
        else $error("switch pair B enable wrong at reset setting");
    idle_term_a: assert property (
        idle |-> rail_en.termination_ldo ==
            (VARIANT_B & $past(seq_en.termination_ldo)))
        else $error("termination LDO enable wrong at reset setting");
    idle_aux3_a: assert property (
        idle |-> rail_en.aux_ldo_three ==
            $past(shared_ldo_switch_enable_pin, 3))
        else $error("aux LDO three not following pin");
    idle_fault_a: assert property (
        idle |-> shutdown_req ==
            $past(|rail_fault.step_down | rail_fault.termination_ldo))
        else $error("shutdown wrong at reset masks");
    idle_od_a: assert property (
        !used_r |-> !open_drain_oe)
        else $error("open drain output driven at reset level");
    low_drive_a: assert property (
        open_drain_o == 1'b0 && sda_o == 1'b0)
        else $error("open drain data not low");
    sda_move_a: assert property (
        $changed(sda_oe) |-> !scl_i)
        else $error("data line moved while clock high");
endmodule

bind rfm_regs rfm_regs_checker #(.VARIANT_B(VARIANT_B)) rfm_regs_checker_i (
    .clk(clk), .arst_n(arst_n), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe),
    .shared_ldo_switch_enable_pin(shared_ldo_switch_enable_pin),
    .switch_a_force_on(switch_a_force_on), .seq_en(seq_en),
    .rail_fault(rail_fault), .rail_en(rail_en),
    .shutdown_req(shutdown_req), .open_drain_o(open_drain_o),
    .open_drain_oe(open_drain_oe)
);

/* File: bench/rfm_host_model.sv */
// I2C host model that writes and reads the register bank
`timescale 1ns/1ps
module rfm_host_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // ****
    // Bus phases of a quarter bit, eight clocks each
    // ****
    // Idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Move both lines, then hold them a quarter bit
    task automatic step(input logic c, input logic l);
        scl <= c;
        sda_low <= l;
        repeat (8) @(posedge clk);
    endtask
    // One bit: data set while clock low, sampled while high
    task automatic bit_io(input logic b, output logic s);
        step(1'b0, !b);
        step(1'b1, !b);
        s = sda;
        step(1'b1, !b);
        step(1'b0, !b);
    endtask
    task automatic start();
        @(posedge clk); // Begin every frame on a clock edge
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1); // Data falls with clock high
        step(1'b0, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0); // Data rises with clock high
    endtask
    // Byte MSB first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, input logic ab,
            output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ab, ack);
    endtask
    // Write one byte at an offset; n is high when any byte went unacked
    task automatic wr(input logic [6:0] a, input logic [7:0] o, d,
            output logic n);
        logic [7:0] x;
        logic k0, k1, k2;
        start();
        xbyte({a, 1'b0}, 1'b1, x, k0);
        xbyte(o, 1'b1, x, k1);
        xbyte(d, 1'b1, x, k2);
        stop();
        n = k0 | k1 | k2;
    endtask
    // Set pointer, repeated START, read one byte and refuse more
    task automatic rd(input logic [6:0] a, input logic [7:0] o,
            output logic [7:0] d, output logic n);
        logic [7:0] x;
        logic k0, k1, k2, k3;
        start();
        xbyte({a, 1'b0}, 1'b1, x, k0);
        xbyte(o, 1'b1, x, k1);
        start();
        xbyte({a, 1'b1}, 1'b1, x, k2);
        xbyte(8'hFF, 1'b1, d, k3);
        stop();
        n = k0 | k1 | k2;
    endtask
endmodule

/* File: bench/rfm_regs_tb_top.sv */
// Self-checking bench for the rail enable and fault mask bank
`timescale 1ns/1ps
module rfm_regs_tb_top;
    localparam logic [6:0] ADDR = 7'h2A; // Arbitrary target address
    logic clk, arst_n, pin, force_a, scl, host_low, sda, nak, sd;
    logic od_o, od_oe, sda_o, sda_oe;
    logic [7:0] rv, c3, m1, m2, g;
    logic [31:0] r;
    rfm_pkg::rfm_seq_t seq;
    rfm_pkg::rfm_fault_t flt;
    rfm_pkg::rfm_rail_en_t en, en_b;
    int err_total, checks_done, cyc, seed;
    // Open-drain data line with pull-up
    assign sda = !(host_low | sda_oe);
    rfm_regs #(.BUS_ADDR(ADDR), .VARIANT_B(1'b0)) rfm_regs_i (
        .clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe),
        .shared_ldo_switch_enable_pin(pin), .switch_a_force_on(force_a),
        .seq_en(seq), .rail_fault(flt), .rail_en(en),
        .shutdown_req(sd), .open_drain_o(od_o), .open_drain_oe(od_oe)
    );
    // Second variant on a parked bus: keeps its reset settings all run
    rfm_regs #(.BUS_ADDR(ADDR), .VARIANT_B(1'b1)) rfm_regs_vb_i (
        .clk(clk), .arst_n(arst_n), .scl_i(1'b1), .sda_i(1'b1),
        .sda_o(), .sda_oe(),
        .shared_ldo_switch_enable_pin(pin), .switch_a_force_on(force_a),
        .seq_en(seq), .rail_fault(flt), .rail_en(en_b),
        .shutdown_req(), .open_drain_o(), .open_drain_oe()
    );
    rfm_host_model rfm_host_model_i (
        .clk(clk), .sda(sda), .scl(scl), .sda_low(host_low)
    );
    // ****
    // Expectations and checks
    // ****
    function automatic logic [7:0] exp_en(input logic [7:0] c,
            input rfm_pkg::rfm_seq_t s, input logic fa, input logic p);
        return {4'h0, c[6] & (c[1] | s.switch_pair_b),
            c[5] & (fa | s.switch_a),
            c[4] & (c[3] | s.termination_ldo), c[0] | p};
    endfunction
    function automatic logic exp_sd(input rfm_pkg::rfm_fault_t f);
        return (|(f.step_down & ~m1[5:0]))
            | (f.switch_a & !m1[6]) | (f.aux_ldo_two & !m1[7])
            | (f.analog_5v_supply & !m2[5]) | (f.aux_ldo_one & !m2[4])
            | (f.aux_ldo_three & !m2[0]) | (f.termination_ldo & !m2[3])
            | (f.switch_pair_b & !(m2[2] & m2[1]));
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Let pin synchroniser and output flops follow, then compare
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
        chk("rail_en", exp_en(c3, seq, force_a, pin), {4'h0, en});
        chk("shutdown_req", {7'h0, exp_sd(flt)}, {7'h0, sd});
        chk("rail_en_b", exp_en(rfm_pkg::RST_RAIL_CTRL3_B, seq, force_a,
            pin), {4'h0, en_b});
    endtask
    task automatic apply(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            r = $random(seed);
            {seq, pin, force_a} <= r[4:0];
            flt <= r[17:5] & r[30:18];
            settle();
        end
    endtask
    // One fault at a time across every rail
    task automatic sweep();
        for (int j = 0; j < $bits(flt); j++) begin
            @(posedge clk);
            flt <= rfm_pkg::rfm_fault_t'(13'h1 << j);
            settle();
        end
    endtask
    task automatic wreg(input logic [7:0] o, d);
        rfm_host_model_i.wr(ADDR, o, d, nak);
        chk("write ack", 8'h00, {7'h0, nak});
    endtask
    task automatic rreg(input logic [7:0] o, e);
        rfm_host_model_i.rd(ADDR, o, rv, nak);
        chk("read ack", 8'h00, {7'h0, nak});
        chk("read data", e, rv);
    endtask
    task automatic reset_dut(input int n);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (n) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        c3 = rfm_pkg::RST_RAIL_CTRL3_A;
        m1 = rfm_pkg::RST_MASK_FIRST;
        m2 = rfm_pkg::RST_MASK_SECOND;
    endtask
    // ****
    // Clock, watchdog and main sequence
    // ****
    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    // Cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        seed = 96022;
        err_total = 0;
        checks_done = 0;
        cyc = 0;
        arst_n = 1'b0;
        {seq, flt, pin, force_a} = 18'h0;
        reset_dut(7);
        apply(40);
        rreg(8'h9F, 8'h68);
        rreg(8'hA1, 8'h20);
        rreg(8'hA2, 8'hC0);
        rreg(8'hA3, 8'h37);
        rreg(8'h9E, 8'h00);
        sweep();
        rfm_host_model_i.wr(ADDR ^ 7'h01, 8'hA1, 8'h00, nak);
        chk("foreign address", 8'h01, {7'h0, nak});
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            c3 = (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : r[7:0];
            m1 = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : r[15:8];
            m2 = (i == 0) ? 8'h00 : {r[23:19], {2{r[18]}}, r[16]}
                | {8{i == 1}};
            g = r[31:24];
            wreg(8'h9F, c3);
            wreg(8'hA1, g);
            wreg(8'hA2, m1);
            wreg(8'hA3, m2);
            m2 = m2 & 8'h7F;
            rreg(8'hA3, m2);
            chk("open_drain_oe", {7'h0, !g[5]}, {7'h0, od_oe});
            apply(6);
            sweep();
        end
        reset_dut(3);
        apply(20);
        rreg(8'hA2, 8'hC0);
        final_report();
    end
endmodule
